/* hdl/byte_buffer.sv */
// Two-entry valid/ready byte buffer between the serial engine and the loader
`timescale 1ns/100ps
module byte_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } buf_state_type;

  buf_state_type s_r;
  buf_state_type s_nxt;
  logic          push;
  logic          pop;

  assign in_ready_o  = (s_r.count != FULL);
  assign out_valid_o = (s_r.count != '0);
  assign out_data_o  = s_r.mem[s_r.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr_ptr] = in_data_i;
      s_nxt.wr_ptr = (s_r.wr_ptr == LAST) ? '0 : s_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd_ptr = (s_r.rd_ptr == LAST) ? '0 : s_r.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.count = s_r.count + 1'b1;
    end else if (pop && !push) begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

/* hdl/config_preloader.sv */
// Power-on loader that copies the EEPROM image into configuration bytes
`timescale 1ns/100ps
module config_preloader (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // Serial interface enabled (pull-up seen on the data line)
  input  wire logic       sb_enable_i,
  // Multibyte read request to the two-wire engine
  output logic            rd_req_o,
  input  wire logic       rd_ack_i,
  output logic      [6:0] rd_slave_addr_o,
  output logic      [7:0] rd_word_addr_o,
  output logic      [7:0] rd_count_o,
  // Byte stream from the engine
  input  wire logic       byte_valid_i,
  output logic            byte_ready_o,
  input  wire logic [7:0] byte_data_i,
  input  wire logic       byte_nack_i,
  // Configuration byte write port
  output logic            cfg_wr_o,
  input  wire logic       cfg_ready_i,
  output logic            cfg_func_o,
  output logic      [7:0] cfg_addr_o,
  output logic      [7:0] cfg_data_o,
  // Status
  output logic            download_busy_flag_o,
  output logic            download_error_o,
  output logic            mini_rom_present_o,
  output logic      [7:0] mini_rom_offset_o,
  output logic      [7:0] link_enh_o
);

  typedef struct packed {
    preload_pkg::state_type state;
    logic [7:0]             word;
    logic                   error;
    logic                   cfg_valid;
    logic                   cfg_func;
    logic [7:0]             cfg_addr;
    logic [7:0]             cfg_data;
    logic [7:0]             mini_rom;
    logic [7:0]             link_enh;
  } loader_state_type;

  loader_state_type s_r;
  loader_state_type s_nxt;
  logic             buf_valid;
  logic             buf_ready;
  logic [7:0]       buf_data;
  logic             take;

  // Maps an image word to its target function and byte offset
  function automatic preload_pkg::target_type word_target(
    input logic [7:0] w
  );
    preload_pkg::target_type t;
    t.wr   = 1'b1;
    t.func = preload_pkg::FUNC_BRIDGE;
    t.addr = '0;
    if (w >= preload_pkg::W_BR_SSID && w < preload_pkg::W_GCTL) begin
      t.addr = preload_pkg::A_BR_SSID + (w - preload_pkg::W_BR_SSID); // see [R03]
    end else if (w >= preload_pkg::W_GCTL && w < preload_pkg::W_VEND0) begin
      t.addr = preload_pkg::A_GCTL + (w - preload_pkg::W_GCTL); // see [R04]
    end else if (w == preload_pkg::W_VEND0) begin
      t.addr = preload_pkg::A_VEND0; // see [R05]
    end else if (w == preload_pkg::W_VEND1) begin
      t.addr = preload_pkg::A_VEND1; // see [R05]
    end else if (w == preload_pkg::W_ARB_CTL) begin
      t.addr = preload_pkg::A_ARB_CTL; // see [R07]
    end else if (w == preload_pkg::W_ARB_MASK) begin
      t.addr = preload_pkg::A_ARB_MASK; // see [R07]
    end else if (w >= preload_pkg::W_TL && w < preload_pkg::W_DLL) begin
      t.addr = preload_pkg::A_TL + (w - preload_pkg::W_TL); // see [R08]
    end else if (w >= preload_pkg::W_DLL && w < preload_pkg::W_PHY) begin
      t.addr = preload_pkg::A_DLL + (w - preload_pkg::W_DLL); // see [R09]
    end else if (w >= preload_pkg::W_PHY && w < preload_pkg::W_PHY_END) begin
      t.addr = preload_pkg::A_PHY + (w - preload_pkg::W_PHY); // see [R10]
    end else if (w == preload_pkg::W_VEND2) begin
      t.addr = preload_pkg::A_VEND2; // see [R05]
    end else if (w == preload_pkg::W_VEND3) begin
      t.addr = preload_pkg::A_VEND3; // see [R05]
    end else if (w == preload_pkg::W_VEND4) begin
      t.addr = preload_pkg::A_VEND4; // see [R05]
    end else if (w == preload_pkg::W_LAT_GNT) begin
      // Latency in the high nibble, grant in the low one, as one byte
      t.func = preload_pkg::FUNC_OHCI;
      t.addr = preload_pkg::A_LAT_GNT; // see [R13]
    end else if (w >= preload_pkg::W_OH_SSID && w < preload_pkg::W_LINK_ENH) begin
      t.func = preload_pkg::FUNC_OHCI;
      t.addr = preload_pkg::A_OH_SSID + (w - preload_pkg::W_OH_SSID); // see [R14]
    end else if (w >= preload_pkg::W_UID_HI && w < preload_pkg::W_UID_END) begin
      // High then low identifier words sit back to back at 24h-2Bh
      t.func = preload_pkg::FUNC_OHCI;
      t.addr = preload_pkg::A_UID_HI + (w - preload_pkg::W_UID_HI); // see [R16]
    end else begin
      // Headers, link enhancement, mini-ROM, reserved and trailer words: no configuration write
      t.wr = 1'b0; // see [R06]
    end
    return t;
  endfunction

  byte_buffer #(
    .WIDTH (preload_pkg::BUF_WIDTH),
    .DEPTH (preload_pkg::BUF_DEPTH)
  ) u_byte_buffer (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (byte_valid_i),
    .in_ready_o  (byte_ready_o),
    .in_data_i   (byte_data_i),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready),
    .out_data_o  (buf_data)
  );

  // A byte leaves the buffer only when the write slot is free or freeing;
  // after the download any leftover bytes are discarded.
  assign buf_ready = ((s_r.state == preload_pkg::ST_LOAD) &&
                      (!s_r.cfg_valid || cfg_ready_i)) ||
                     (s_r.state == preload_pkg::ST_DONE);
  assign take      = buf_valid && buf_ready &&
                     (s_r.state == preload_pkg::ST_LOAD);

  assign rd_req_o        = (s_r.state == preload_pkg::ST_REQ);
  assign rd_slave_addr_o = preload_pkg::EEPROM_SLAVE_ADDR; // see [R18]
  assign rd_word_addr_o  = preload_pkg::START_WORD;
  assign rd_count_o      = preload_pkg::IMAGE_BYTES;

  assign cfg_wr_o   = s_r.cfg_valid;
  assign cfg_func_o = s_r.cfg_func;
  assign cfg_addr_o = s_r.cfg_addr;
  assign cfg_data_o = s_r.cfg_data;

  assign download_busy_flag_o = (s_r.state == preload_pkg::ST_REQ) ||
                                (s_r.state == preload_pkg::ST_LOAD) ||
                                s_r.cfg_valid; // see [R19]
  assign download_error_o     = s_r.error;
  assign mini_rom_offset_o    = s_r.mini_rom;
  assign mini_rom_present_o   = (s_r.mini_rom != preload_pkg::NO_MINI_ROM); // see [R15]
  assign link_enh_o           = s_r.link_enh;

  always_comb begin
    preload_pkg::target_type t;
    logic                    bad;
    t     = word_target(s_r.word);
    bad   = 1'b0;
    s_nxt = s_r;
    if (s_r.cfg_valid && cfg_ready_i) begin
      s_nxt.cfg_valid = 1'b0;
    end
    case (s_r.state)
      preload_pkg::ST_IDLE: begin
        // Starts on its own once reset is gone
        if (sb_enable_i) begin
          s_nxt.state = preload_pkg::ST_REQ; // see [R17]
        end else begin
          s_nxt.state = preload_pkg::ST_DONE;
        end
      end
      preload_pkg::ST_REQ: begin
        if (byte_nack_i) begin
          s_nxt.error = 1'b1; // see [R19]
          s_nxt.state = preload_pkg::ST_DONE;
        end else if (rd_ack_i) begin
          s_nxt.state = preload_pkg::ST_LOAD;
        end
      end
      preload_pkg::ST_LOAD: begin
        if (byte_nack_i) begin
          s_nxt.error = 1'b1; // see [R19]
          s_nxt.state = preload_pkg::ST_DONE;
        end else if (take) begin
          s_nxt.word = s_r.word + 1'b1; // see [R21]
          if (t.wr) begin
            s_nxt.cfg_valid = 1'b1;
            s_nxt.cfg_func  = t.func;
            s_nxt.cfg_addr  = t.addr;
            s_nxt.cfg_data  = buf_data;
          end
          case (s_r.word)
            preload_pkg::W_BR_IND:
              bad = (buf_data != preload_pkg::BR_IND_VAL); // see [R01]
            preload_pkg::W_BR_CNT:
              bad = (buf_data != preload_pkg::BR_CNT_VAL); // see [R02]
            preload_pkg::W_OH_IND:
              bad = (buf_data != preload_pkg::OH_IND_VAL); // see [R11]
            preload_pkg::W_OH_CNT:
              bad = (buf_data != preload_pkg::OH_CNT_VAL); // see [R12]
            preload_pkg::W_END:
              bad = (buf_data != preload_pkg::END_VAL); // see [R20]
            preload_pkg::W_MINI_ROM:
              s_nxt.mini_rom = buf_data; // see [R15]
            preload_pkg::W_LINK_ENH:
              s_nxt.link_enh = buf_data;
            default: begin
              bad = 1'b0;
            end
          endcase
          if (bad) begin
            // A malformed image stops the load; earlier bytes stay written
            s_nxt.error = 1'b1; // see [R19]
            s_nxt.state = preload_pkg::ST_DONE;
          end else if (s_r.word == preload_pkg::W_END) begin
            s_nxt.state = preload_pkg::ST_DONE;
          end
        end
      end
      preload_pkg::ST_DONE: begin
        s_nxt.state = preload_pkg::ST_DONE;
      end
      default: begin
        s_nxt.state = preload_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

/* pkg/preload_pkg.sv */
// Constants, types and image layout for the power-on configuration loader
// How it works
// [R01] Image word 00h holds the bridge function indicator 00h.
// [R02] Image word 01h holds the bridge byte count 1Eh.
// [R03] Words 02h-05h go to bridge subsystem IDs at 84h-87h, low byte first.
// [R04] Words 06h-09h go to bridge general control bytes D4h-D7h in order.
// [R05] Words 0Ah,0Bh,1Dh,1Eh,1Fh go to vendor bytes D8h,D9h,E0h,E2h,E3h.
// [R06] Words 0Ch,1Bh,1Ch are consumed and update nothing.
// [R07] Word 0Dh goes to arbiter control DCh, word 0Eh to request mask DDh.
// [R08] Words 0Fh-12h fill transaction layer control bytes C0h-C3h.
// [R09] Words 13h-16h fill data link layer control bytes C4h-C7h.
// [R10] Words 17h-1Ah fill physical layer control bytes C8h-CBh.
// [R11] Image word 20h holds the link function indicator 01h.
// [R12] Image word 21h holds the link function byte count 18h.
// [R13] Word 22h: high nibble max latency, low nibble min grant, byte 3Fh.
// [R14] Words 23h-26h go to link subsystem IDs at 2Ch-2Fh, low byte first.
// [R15] Word 28h is the mini-ROM offset; 00h means no mini-ROM present.
// [R16] Words 29h-2Ch: unique_id_high 24h-27h; 2Dh-30h: unique_id_low 28h-2Bh.
// [R17] Download starts by itself as one multibyte read right after reset.
// [R18] EEPROM is always addressed at fixed slave address 1010000b.
// [R19] Busy flag is high during download; error flag reports a failed one.
// [R20] Image word 3Ah holds the end-of-list marker 80h.
// [R21] Bytes written in ascending word order; untouched targets keep defaults.
package preload_pkg;

  localparam logic [6:0] EEPROM_SLAVE_ADDR = 7'h50;
  localparam logic [7:0] START_WORD        = 8'h00;
  localparam logic [7:0] IMAGE_BYTES       = 8'h3b;

  // Image word addresses
  localparam logic [7:0] W_BR_IND    = 8'h00;
  localparam logic [7:0] W_BR_CNT    = 8'h01;
  localparam logic [7:0] W_BR_SSID   = 8'h02;
  localparam logic [7:0] W_GCTL      = 8'h06;
  localparam logic [7:0] W_VEND0     = 8'h0a;
  localparam logic [7:0] W_VEND1     = 8'h0b;
  localparam logic [7:0] W_ARB_CTL   = 8'h0d;
  localparam logic [7:0] W_ARB_MASK  = 8'h0e;
  localparam logic [7:0] W_TL        = 8'h0f;
  localparam logic [7:0] W_DLL       = 8'h13;
  localparam logic [7:0] W_PHY       = 8'h17;
  localparam logic [7:0] W_PHY_END   = 8'h1b;
  localparam logic [7:0] W_VEND2     = 8'h1d;
  localparam logic [7:0] W_VEND3     = 8'h1e;
  localparam logic [7:0] W_VEND4     = 8'h1f;
  localparam logic [7:0] W_OH_IND    = 8'h20;
  localparam logic [7:0] W_OH_CNT    = 8'h21;
  localparam logic [7:0] W_LAT_GNT   = 8'h22;
  localparam logic [7:0] W_OH_SSID   = 8'h23;
  localparam logic [7:0] W_LINK_ENH  = 8'h27;
  localparam logic [7:0] W_MINI_ROM  = 8'h28;
  localparam logic [7:0] W_UID_HI    = 8'h29;
  localparam logic [7:0] W_UID_LO    = 8'h2d;
  localparam logic [7:0] W_UID_END   = 8'h31;
  localparam logic [7:0] W_END       = 8'h3a;

  // Expected header and trailer values, and the no-mini-ROM offset
  localparam logic [7:0] BR_IND_VAL  = 8'h00;
  localparam logic [7:0] BR_CNT_VAL  = 8'h1e;
  localparam logic [7:0] OH_IND_VAL  = 8'h01;
  localparam logic [7:0] OH_CNT_VAL  = 8'h18;
  localparam logic [7:0] END_VAL     = 8'h80;
  localparam logic [7:0] NO_MINI_ROM = 8'h00;

  // Target configuration byte offsets
  localparam logic [7:0] A_BR_SSID   = 8'h84;
  localparam logic [7:0] A_GCTL      = 8'hd4;
  localparam logic [7:0] A_VEND0     = 8'hd8;
  localparam logic [7:0] A_VEND1     = 8'hd9;
  localparam logic [7:0] A_ARB_CTL   = 8'hdc;
  localparam logic [7:0] A_ARB_MASK  = 8'hdd;
  localparam logic [7:0] A_TL        = 8'hc0;
  localparam logic [7:0] A_DLL       = 8'hc4;
  localparam logic [7:0] A_PHY       = 8'hc8;
  localparam logic [7:0] A_VEND2     = 8'he0;
  localparam logic [7:0] A_VEND3     = 8'he2;
  localparam logic [7:0] A_VEND4     = 8'he3;
  localparam logic [7:0] A_LAT_GNT   = 8'h3f;
  localparam logic [7:0] A_OH_SSID   = 8'h2c;
  localparam logic [7:0] A_UID_HI    = 8'h24;

  localparam logic       FUNC_BRIDGE = 1'b0;
  localparam logic       FUNC_OHCI   = 1'b1;

  localparam int         BUF_WIDTH   = 8;
  localparam int         BUF_DEPTH   = 2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_LOAD,
    ST_DONE
  } state_type;

  typedef struct packed {
    logic       wr;
    logic       func;
    logic [7:0] addr;
  } target_type;

endpackage

/* testbench/config_preloader_properties.sv */
// Port assertions and covers for the configuration loader
`timescale 1ns/100ps
module preload_checker (
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic       rd_req_o,
  input wire logic       rd_ack_i,
  input wire logic [6:0] rd_slave_addr_o,
  input wire logic       byte_nack_i,
  input wire logic       cfg_wr_o,
  input wire logic       cfg_ready_i,
  input wire logic       cfg_func_o,
  input wire logic [7:0] cfg_addr_o,
  input wire logic [7:0] cfg_data_o,
  input wire logic       download_busy_flag_o,
  input wire logic       download_error_o,
  input wire logic       mini_rom_present_o,
  input wire logic [7:0] mini_rom_offset_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_slave_fixed: assert property (
    rd_req_o |-> rd_slave_addr_o == 7'h50) else $error("slave address");
  a_req_hold: assert property (
    rd_req_o && !rd_ack_i && !byte_nack_i |=> rd_req_o)
    else $error("request lost");
  a_req_once: assert property (
    rd_req_o && rd_ack_i |=> !rd_req_o [*8]) else $error("request again");
  a_busy_work: assert property (
    rd_req_o || cfg_wr_o |-> download_busy_flag_o) else $error("busy low");
  a_wr_hold: assert property (
    cfg_wr_o && !cfg_ready_i |=> cfg_wr_o &&
    $stable({cfg_func_o, cfg_addr_o, cfg_data_o})) else $error("write moved");
  a_err_sticky: assert property (
    download_error_o |=> download_error_o) else $error("error cleared");
  a_err_stops: assert property (
    download_error_o && !cfg_wr_o |=> !cfg_wr_o)
    else $error("write after error");
  a_nack_err: assert property (
    byte_nack_i && download_busy_flag_o |=> download_error_o)
    else $error("nack ignored");
  a_mini_rom: assert property (
    mini_rom_present_o == (mini_rom_offset_o != 8'h00))
    else $error("mini rom flag");
  c_ack: cover property (rd_req_o && rd_ack_i);
  c_write: cover property (cfg_wr_o && cfg_ready_i);
  c_error: cover property ($rose(download_error_o));
endmodule
bind config_preloader preload_checker u_preload_checker (.*);

/* testbench/eeprom_model.sv */
// Serial engine with EEPROM image behind it, feeding the loader
`timescale 1ns/100ps
module eeprom_model (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       rd_req_i,
  input  wire logic [6:0] slave_addr_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] bad_word_i,
  input  wire logic [7:0] nack_at_i,
  input  wire logic       byte_ready_i,
  output logic            rd_ack_o,
  output logic            byte_valid_o,
  output logic      [7:0] byte_data_o,
  output logic            byte_nack_o
);
  int   idx = -1;
  logic rst;
  logic req;
  logic hs;
  logic ack;
  logic nk;
  logic nv;
  logic skip = 1'b0;
  function automatic logic [7:0] img(input logic [7:0] w);
    case (w)
      8'h01:   img = 8'h1e;
      8'h20:   img = 8'h01;
      8'h21:   img = 8'h18;
      8'h3a:   img = 8'h80;
      8'h00, 8'h0a, 8'h0b, 8'h1d, 8'h1e, 8'h1f:
               img = 8'h00;
      8'h0c, 8'h1b, 8'h1c:
               img = 8'h00;
      default: img = w ^ 8'ha5;
    endcase
  endfunction
  initial begin
    rd_ack_o     = 1'b0;
    byte_valid_o = 1'b0;
    byte_nack_o  = 1'b0;
    byte_data_o  = 8'h3c;
  end
  always @(posedge core_clk_i) begin
    rst = reset_i;
    req = rd_req_i;
    hs  = byte_valid_o && byte_ready_i;
    #1;
    ack  = 1'b0;
    nk   = 1'b0;
    nv   = byte_valid_o && !hs;
    skip = slow_i && !skip;
    if (hs) idx++;
    if (rst) begin
      idx = -1;
      nv  = 1'b0;
    end else if (idx == -1 && req) begin
      ack = (slave_addr_i == 7'h50);
      nk  = (slave_addr_i != 7'h50);
      idx = (slave_addr_i == 7'h50) ? 0 : -2;
    end else if (idx >= 0 && idx < 59 && !nv && !skip) begin
      if (8'(idx) == nack_at_i) begin
        nk  = 1'b1;
        idx = -2;
      end else begin
        nv          = 1'b1;
        byte_data_o = img(8'(idx)) ^
                      ((8'(idx) == bad_word_i) ? 8'hff : 8'h00);
      end
    end
    // Each output is written once per cycle
    rd_ack_o     = ack;
    byte_nack_o  = nk;
    byte_valid_o = nv;
    // Released data line never keeps its last value
    if (!nv) byte_data_o = ~byte_data_o;
  end
endmodule

/* testbench/tb.sv */
// Self-checking bench for the configuration loader
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [7:0] w;
    logic       f;
    logic [7:0] a;
    logic [3:0] n;
  } seg_type;
  // First image word, function, first offset, byte count
  seg_type rows [15] = '{
    '{8'h02, 1'b0, 8'h84, 4'h4}, '{8'h06, 1'b0, 8'hd4, 4'h4},
    '{8'h0a, 1'b0, 8'hd8, 4'h1}, '{8'h0b, 1'b0, 8'hd9, 4'h1},
    '{8'h0d, 1'b0, 8'hdc, 4'h1}, '{8'h0e, 1'b0, 8'hdd, 4'h1},
    '{8'h0f, 1'b0, 8'hc0, 4'h4}, '{8'h13, 1'b0, 8'hc4, 4'h4},
    '{8'h17, 1'b0, 8'hc8, 4'h4}, '{8'h1d, 1'b0, 8'he0, 4'h1},
    '{8'h1e, 1'b0, 8'he2, 4'h1}, '{8'h1f, 1'b0, 8'he3, 4'h1},
    '{8'h22, 1'b1, 8'h3f, 4'h1}, '{8'h23, 1'b1, 8'h2c, 4'h4},
    '{8'h29, 1'b1, 8'h24, 4'h8}};
  // Corrupted header or trailer word beside the writes that still complete
  logic [15:0] bad_rows [5] = '{16'h0000, 16'h0100, 16'h201b, 16'h211b,
                                16'h3a28};
  logic        core_clk_i = 1'b0, reset_i = 1'b1, sb_enable_i = 1'b1;
  logic        cfg_ready_i = 1'b1, slow = 1'b0;
  logic [7:0]  bad_word = 8'hff, nack_at = 8'hff;
  logic        rd_req_o, rd_ack_i, byte_valid_i, byte_ready_o, byte_nack_i;
  logic        cfg_wr_o, cfg_func_o, download_busy_flag_o, download_error_o;
  logic        mini_rom_present_o;
  logic [6:0]  rd_slave_addr_o;
  logic [7:0]  rd_word_addr_o, rd_count_o, byte_data_i, cfg_addr_o;
  logic [7:0]  cfg_data_o, mini_rom_offset_o, link_enh_o;
  logic [16:0] wq [$];
  int          fails = 0, cmp_count = 0, cyc = 0;

  always #2.5 core_clk_i = ~core_clk_i;
  config_preloader u_config_preloader (.*);
  eeprom_model u_eeprom_model (
    .core_clk_i   (core_clk_i),
    .reset_i      (reset_i),
    .rd_req_i     (rd_req_o),
    .slave_addr_i (rd_slave_addr_o),
    .slow_i       (slow),
    .bad_word_i   (bad_word),
    .nack_at_i    (nack_at),
    .byte_ready_i (byte_ready_o),
    .rd_ack_o     (rd_ack_i),
    .byte_valid_o (byte_valid_i),
    .byte_data_o  (byte_data_i),
    .byte_nack_o  (byte_nack_i)
  );

  always @(posedge core_clk_i) begin
    cyc++;
    if (cfg_wr_o && cfg_ready_i)
      wq.push_back({cfg_func_o, cfg_addr_o, cfg_data_o});
    if (cyc == 20000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end

  task automatic cmp_flag(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s is %b", $time, what, got);
    end
  endtask

  task automatic cmp_wr(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t write %h expected %h", $time, got, exp);
    end
  endtask

  task automatic go(input logic sb, input logic [7:0] bad, input logic [7:0] nk,
                    input logic sl, input logic stall);
    int n;
    n = 0;
    @(posedge core_clk_i);
    #1 reset_i = 1'b1;
    sb_enable_i = sb;
    bad_word = bad;
    nack_at = nk;
    slow = sl;
    repeat (12) @(posedge core_clk_i);
    cmp_flag(download_busy_flag_o, 1'b0, "busy in reset");
    cmp_flag(byte_ready_o, 1'b1, "ready in reset");
    #1 reset_i = 1'b0;
    wq.delete();
    repeat (2) @(posedge core_clk_i);
    #1 cmp_flag(rd_req_o, sb, "read request");
    cmp_flag(download_busy_flag_o, sb, "busy");
    if (stall) begin
      repeat (20) @(posedge core_clk_i);
      #1 cfg_ready_i = 1'b0;
      repeat (30) @(posedge core_clk_i);
      #1 cmp_flag(byte_ready_o, 1'b0, "buffer full");
      cfg_ready_i = 1'b1;
    end
    while (download_busy_flag_o !== 1'b0 && n < 2000) begin
      @(posedge core_clk_i);
      n++;
    end
    cmp_flag(n < 2000, 1'b1, "busy stuck");
    repeat (4) @(posedge core_clk_i);
  endtask

  task automatic check_writes(input int nexp);
    int k;
    k = 0;
    foreach (rows[i]) begin
      for (int j = 0; j < int'(rows[i].n); j++) begin
        if (k < nexp && k < wq.size())
          cmp_wr(wq[k], {rows[i].f, rows[i].a + 8'(j),
                 u_eeprom_model.img(rows[i].w + 8'(j))});
        k++;
      end
    end
    cmp_wr(17'(wq.size()), 17'(nexp));
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    go(1'b1, 8'hff, 8'hff, 1'b0, 1'b1);
    check_writes(40);
    cmp_flag(download_error_o, 1'b0, "error");
    cmp_flag(mini_rom_present_o, 1'b1, "mini rom");
    cmp_wr({9'h0, mini_rom_offset_o}, {9'h0, 8'h8d});
    cmp_wr({9'h0, rd_word_addr_o}, {9'h0, 8'h00});
    cmp_wr({9'h0, rd_count_o}, {9'h0, 8'h3b});
    cmp_wr({9'h0, link_enh_o}, {9'h0, 8'h82});
    foreach (bad_rows[i]) begin
      go(1'b1, bad_rows[i][15:8], 8'hff, 1'b1, 1'b0);
      check_writes(int'(bad_rows[i][7:0]));
      cmp_flag(download_error_o, 1'b1, "header error");
    end
    go(1'b1, 8'hff, 8'h10, 1'b0, 1'b0);
    cmp_flag(download_error_o, 1'b1, "nack error");
    cmp_flag(wq.size() <= 13, 1'b1, "writes after nack");
    go(1'b0, 8'hff, 8'hff, 1'b0, 1'b0);
    cmp_flag(download_error_o | download_busy_flag_o, 1'b0, "idle");
    results();
  end
endmodule
